// ### inc/baud_gen_pkg.sv
`default_nettype none
package baud_gen_pkg;

	// ----------------------------------------------------------------
	// Serial modes
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		MODE_SHIFT = 2'h0,
		MODE_8BIT_VAR = 2'h1,
		MODE_9BIT_FIXED = 2'h2,
		MODE_9BIT_VAR = 2'h3
	} serial_mode_e;

	// ----------------------------------------------------------------
	// Division constants
	// ----------------------------------------------------------------
	localparam int unsigned CORE_CLOCK_HZ = 100_000_000;
	localparam logic [3:0] MODE0_DIVIDE = 4'hC;
	localparam logic [5:0] MODE2_DIVIDE_SLOW = 6'h3F;
	localparam logic [5:0] MODE2_DIVIDE_FAST = 6'h1F;
	localparam logic [3:0] OVERFLOWS_PER_BIT = 4'hF;
	localparam logic [4:0] T1_DIVIDE_SLOW = 5'h1F;
	localparam logic [4:0] T1_DIVIDE_FAST = 5'h0F;
	localparam logic [3:0] T1_PRESCALE = 4'hB;
	localparam logic [7:0] T1_RELOAD_RESET = 8'h00;
	localparam logic [15:0] T2_RELOAD_RESET = 16'h0000;

endpackage : baud_gen_pkg
`default_nettype wire

// ### design/overflow_divider.sv
`timescale 1ns/1ps
`default_nettype none

module overflow_divider
	import baud_gen_pkg::*;
(
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	// Control
	input  wire logic       enable,
	input  wire logic       step,
	input  wire logic [4:0] terminal,
	// Result
	output logic            tick
);

	typedef struct packed
	{
		logic [4:0] count;
		logic       tick;
	} div_state_s;

	div_state_s state;
	div_state_s next_state;

	always_comb
	begin
		next_state = state;
		next_state.tick = 1'b0;
		if (!enable)
		begin
			next_state.count = 5'h00;
		end
		else if (step)
		begin
			if (state.count >= terminal)
			begin
				next_state.count = 5'h00;
				next_state.tick = 1'b1;
			end
			else
			begin
				next_state.count = state.count + 5'h01;
			end
		end
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			state <= '0;
		end
		else
		begin
			state <= next_state;
		end
	end

	assign tick = state.tick;

endmodule : overflow_divider

`default_nettype wire

// ### design/uart_baud_rate_generator.sv
// Function
// - Mode 2: core/64, or /32 doubled
// - Modes 1,3 rate from timer overflows
// - Timer 1: overflow times 2^double over 32
// - Timer 1 auto-reload: clock/(12*(256-reload))
// - Timer 2: one bit per 16 overflows
// - Timer 2 counts every two clocks
// - Select bits put timer 2 per direction
// - Timer 2 reloads 16-bit capture value
// - Mode 0 shift clock is core/12
// - Two mode bits select serial mode
`timescale 1ns/1ps
`default_nettype none

module uart_baud_rate_generator
	import baud_gen_pkg::*;
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	// Mode selection
	input  wire logic        serial_mode_bit_hi,
	input  wire logic        serial_mode_bit_lo,
	input  wire logic        rate_double_bit,
	input  wire logic        tx_timer2_select,
	input  wire logic        rx_timer2_select,
	// Timer 1 source
	input  wire logic        timer1_overflow,
	input  wire logic        timer1_internal_run,
	input  wire logic [7:0]  timer1_reload_byte,
	// Timer 2 reload
	input  wire logic [7:0]  timer2_reload_high,
	input  wire logic [7:0]  timer2_reload_low,
	// Bit ticks to shifters, and timer 2 overflow
	output logic             tx_bit_tick,
	output logic             rx_bit_tick,
	output logic             timer2_overflow
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic [3:0]  m0_count;
		logic [5:0]  m2_count;
		logic [3:0]  t1_prescale;
		logic [7:0]  t1_count;
		logic        t1_overflow;
		logic        t2_phase;
		logic [15:0] t2_count;
		logic        t2_overflow;
		logic        tx_tick;
		logic        rx_tick;
	} gen_state_s;

	gen_state_s state;
	gen_state_s next_state;

	serial_mode_e mode;
	logic         variable_rate;
	logic         t2_active;
	logic         t1_source;
	logic         t1_step;
	logic         tx_div_tick;
	logic         rx_div_tick;
	logic [4:0]   t1_terminal;
	logic [4:0]   tx_terminal;
	logic [4:0]   rx_terminal;
	logic         tx_step;
	logic         rx_step;

	assign mode = serial_mode_e'({serial_mode_bit_hi, serial_mode_bit_lo});
	assign variable_rate = (mode == MODE_8BIT_VAR) || (mode == MODE_9BIT_VAR);
	assign t2_active = tx_timer2_select || rx_timer2_select;

	// External and internal timer 1 overflows are ORed into one source
	assign t1_source = timer1_overflow || state.t1_overflow;

	// divide by 32, or 16 when doubled
	assign t1_terminal = rate_double_bit ? T1_DIVIDE_FAST : T1_DIVIDE_SLOW;

	// clear select falls back to timer 1
	assign tx_step = tx_timer2_select ? state.t2_overflow : t1_source;
	assign rx_step = rx_timer2_select ? state.t2_overflow : t1_source;
	assign tx_terminal = tx_timer2_select ? {1'b0, OVERFLOWS_PER_BIT}
		: t1_terminal;
	assign rx_terminal = rx_timer2_select ? {1'b0, OVERFLOWS_PER_BIT}
		: t1_terminal;
	assign t1_step = timer1_internal_run
		&& (state.t1_prescale == T1_PRESCALE);

	// ----------------------------------------------------------------
	// Overflow dividers
	// ----------------------------------------------------------------
	// per-direction overflow counting
	overflow_divider tx_divider
	(
		.clock    (clock),
		.reset    (reset),
		.enable   (variable_rate),
		.step     (tx_step),
		.terminal (tx_terminal),
		.tick     (tx_div_tick)
	);

	overflow_divider rx_divider
	(
		.clock    (clock),
		.reset    (reset),
		.enable   (variable_rate),
		.step     (rx_step),
		.terminal (rx_terminal),
		.tick     (rx_div_tick)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_state.t1_overflow = 1'b0;
		next_state.t2_overflow = 1'b0;
		next_state.tx_tick = 1'b0;
		next_state.rx_tick = 1'b0;

		if (!timer1_internal_run)
		begin
			next_state.t1_prescale = 4'h0;
			next_state.t1_count = timer1_reload_byte;
		end
		else if (t1_step)
		begin
			next_state.t1_prescale = 4'h0;
			if (state.t1_count == 8'hFF)
			begin
				next_state.t1_count = timer1_reload_byte;
				next_state.t1_overflow = 1'b1;
			end
			else
			begin
				next_state.t1_count = state.t1_count + 8'h01;
			end
		end
		else
		begin
			next_state.t1_prescale = state.t1_prescale + 4'h1;
		end

		// timer 2 steps every second clock
		if (!t2_active)
		begin
			next_state.t2_phase = 1'b0;
			next_state.t2_count = {timer2_reload_high, timer2_reload_low};
		end
		else
		begin
			next_state.t2_phase = !state.t2_phase;
			if (state.t2_phase)
			begin
				if (state.t2_count == 16'hFFFF)
				begin
					next_state.t2_count =
						{timer2_reload_high, timer2_reload_low};
					next_state.t2_overflow = 1'b1;
				end
				else
				begin
					next_state.t2_count = state.t2_count + 16'h0001;
				end
			end
		end

		// Fixed-rate prescalers run only in their own mode
		next_state.m0_count = 4'h0;
		next_state.m2_count = 6'h00;
		unique case (mode)
			MODE_SHIFT:
			begin
				if (state.m0_count == MODE0_DIVIDE - 4'h1)
				begin
					next_state.tx_tick = 1'b1;
					next_state.rx_tick = 1'b1;
				end
				else
				begin
					next_state.m0_count = state.m0_count + 4'h1;
				end
			end
			MODE_9BIT_FIXED:
			begin
				if (state.m2_count >= (rate_double_bit
					? MODE2_DIVIDE_FAST : MODE2_DIVIDE_SLOW))
				begin
					next_state.tx_tick = 1'b1;
					next_state.rx_tick = 1'b1;
				end
				else
				begin
					next_state.m2_count = state.m2_count + 6'h01;
				end
			end
			MODE_8BIT_VAR, MODE_9BIT_VAR:
			begin
				next_state.tx_tick = tx_div_tick;
				next_state.rx_tick = rx_div_tick;
			end
		endcase
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			state <= '{
				t1_count: T1_RELOAD_RESET,
				t2_count: T2_RELOAD_RESET,
				default: '0
			};
		end
		else
		begin
			state <= next_state;
		end
	end

	assign tx_bit_tick = state.tx_tick;
	assign rx_bit_tick = state.rx_tick;
	assign timer2_overflow = state.t2_overflow;

endmodule : uart_baud_rate_generator

`default_nettype wire

// ### sim/baud_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module baud_checker (
	// Watched ports
	input wire logic clock,
	input wire logic reset,
	input wire logic serial_mode_bit_hi,
	input wire logic serial_mode_bit_lo,
	input wire logic rate_double_bit,
	input wire logic tx_timer2_select,
	input wire logic rx_timer2_select,
	input wire logic tx_bit_tick,
	input wire logic rx_bit_tick,
	input wire logic timer2_overflow
);
	// ---
	// Checks
	// ---
	wire m0 = !serial_mode_bit_hi && !serial_mode_bit_lo;
	wire m2 = serial_mode_bit_hi && !serial_mode_bit_lo;
	wire t2 = tx_timer2_select || rx_timer2_select;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	tx_pulse_a: assert property (tx_bit_tick |=> !tx_bit_tick)
		else $error("tx tick too long");
	rx_pulse_a: assert property (rx_bit_tick |=> !rx_bit_tick)
		else $error("rx tick too long");
	shift_rate_a: assert property (m0 && rx_bit_tick |-> ##12
		(rx_bit_tick || !m0)) else $error("mode 0 gap");
	slow_rate_a: assert property (m2 && !rate_double_bit && tx_bit_tick
		|-> ##64 (tx_bit_tick || !m2 || rate_double_bit))
		else $error("mode 2 slow gap");
	fast_rate_a: assert property (m2 && rate_double_bit && rx_bit_tick
		|-> ##32 (rx_bit_tick || !m2 || !rate_double_bit))
		else $error("mode 2 fast gap");
	t2_idle_a: assert property (!t2 [*3] |-> !timer2_overflow)
		else $error("timer 2 runs unselected");
	t2_pace_a: assert property (timer2_overflow |=> !timer2_overflow)
		else $error("timer 2 too fast");
	quiet_start_a: assert property ($fell(reset) |-> !tx_bit_tick &&
		!rx_bit_tick && !timer2_overflow) else $error("tick at start");
	cover property (m0 && rx_bit_tick);
	cover property (m2 && rate_double_bit && rx_bit_tick);
	cover property (timer2_overflow);
endmodule : baud_checker
bind uart_baud_rate_generator baud_checker i_check (.clock, .reset,
	.serial_mode_bit_hi, .serial_mode_bit_lo, .rate_double_bit,
	.tx_timer2_select, .rx_timer2_select, .tx_bit_tick, .rx_bit_tick,
	.timer2_overflow);
`default_nettype wire

// ### sim/shifter_model.sv
`timescale 1ns/1ps
`default_nettype none
module shifter_model (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset,
	// Bit ticks
	input  wire logic        tx_bit_tick,
	input  wire logic        rx_bit_tick,
	// Last spacing seen
	output logic      [15:0] tx_gap,
	output logic      [15:0] rx_gap
);
	// ---
	// Shift bookkeeping
	// ---
	logic [15:0] tx_age;
	logic [15:0] rx_age;
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			{tx_age, rx_age, tx_gap, rx_gap} <= '0;
		end
		else
		begin
			tx_age <= tx_bit_tick ? 16'h0001 : tx_age + 16'h0001;
			rx_age <= rx_bit_tick ? 16'h0001 : rx_age + 16'h0001;
			tx_gap <= tx_bit_tick ? tx_age : tx_gap;
			rx_gap <= rx_bit_tick ? rx_age : rx_gap;
		end
	end
endmodule : shifter_model
`default_nettype wire

// ### sim/test_uart_baud_rate_generator.sv
`timescale 1ns/1ps
`default_nettype none
module test_uart_baud_rate_generator;
	// ---
	// Stimulus and checking
	// ---
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic [1:0]  mode = 2'h0;
	logic        dbl = 1'b0;
	logic        tsel = 1'b0;
	logic        rsel = 1'b0;
	logic        ovf = 1'b0;
	logic        run = 1'b0;
	logic [7:0]  t1 = 8'hFF;
	logic [15:0] t2 = 16'hFFFF;
	logic        txt;
	logic        rxt;
	logic [15:0] txg;
	logic [15:0] rxg;
	logic        t2o;
	logic        soft_run = 1'b0;
	logic        soft_ovf = 1'b0;
	logic [15:0] soft_count = 16'h0000;
	localparam logic [15:0] SOFT_RELOAD = 16'hFFFC;
	int          mismatches = 0;
	int          n_compared = 0;
	always #5 clock = ~clock;
	uart_baud_rate_generator i_dut (.clock, .reset,
		.serial_mode_bit_hi(mode[1]), .serial_mode_bit_lo(mode[0]),
		.rate_double_bit(dbl), .tx_timer2_select(tsel),
		.rx_timer2_select(rsel), .timer1_overflow(ovf | soft_ovf),
		.timer1_internal_run(run), .timer1_reload_byte(t1),
		.timer2_reload_high(t2[15:8]), .timer2_reload_low(t2[7:0]),
		.tx_bit_tick(txt), .rx_bit_tick(rxt), .timer2_overflow(t2o));
	shifter_model i_far (.clock, .reset, .tx_bit_tick(txt),
		.rx_bit_tick(rxt), .tx_gap(txg), .rx_gap(rxg));
	always @(negedge clock)
	begin
		soft_ovf <= 1'b0;
		if (!soft_run)
		begin
			soft_count <= SOFT_RELOAD;
		end
		else if (soft_count == 16'hFFFF)
		begin
			soft_count <= SOFT_RELOAD;
			soft_ovf <= 1'b1;
		end
		else
		begin
			soft_count <= soft_count + 16'h0001;
		end
	end
	task automatic summarize;
		if (mismatches == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	task automatic compare(input string what, input logic [15:0] e,
		input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %0d seen %0d", what, e, g);
		end
	endtask : compare
	// Three ticks each way so the first, unaligned gap is gone
	task automatic settle(input int lim, input logic [15:0] te,
		input logic [15:0] re);
		int t;
		int r;
		int i;
		t = 0;
		r = 0;
		for (i = 0; i < lim && (t < 3 || r < 3); i++)
		begin
			@(negedge clock);
			t += int'(txt === 1'b1);
			r += int'(rxt === 1'b1);
		end
		if (t < 3 || r < 3)
		begin
			mismatches++;
			$display("CHECK FAILED tick wait expected 6 seen %0d", t + r);
			summarize();
		end
		else
		begin
			compare("tx gap", te, txg);
			compare("rx gap", re, rxg);
		end
	endtask : settle
	// Spacing of two timer 2 overflow pulses
	task automatic overflow_gap(input logic [15:0] e);
		int i;
		int seen;
		int gap;
		seen = 0;
		gap = 0;
		for (i = 0; i < 100 && seen < 2; i++)
		begin
			@(negedge clock);
			gap += int'(seen == 1);
			seen += int'(t2o === 1'b1);
		end
		if (seen < 2)
		begin
			mismatches++;
			$display("CHECK FAILED overflows expected 2 seen %0d",
				seen);
			summarize();
		end
		else
		begin
			compare("overflow gap", e, 16'(gap));
		end
	endtask : overflow_gap
	task automatic shift_mode;
		mode = 2'h0;
		settle(100, 16'h000C, 16'h000C);
	endtask : shift_mode
	task automatic fixed_mode;
		mode = 2'h2;
		settle(400, 16'h0040, 16'h0040);
		dbl = 1'b1;
		settle(400, 16'h0020, 16'h0020);
	endtask : fixed_mode
	task automatic timer1_mode;
		mode = 2'h3;
		dbl = 1'b0;
		ovf = 1'b1;
		settle(200, 16'h0020, 16'h0020);
		dbl = 1'b1;
		settle(200, 16'h0010, 16'h0010);
		mode = 2'h1;
		ovf = 1'b0;
		run = 1'b1;
		t1 = 8'hFE;
		settle(2000, 16'h0180, 16'h0180);
	endtask : timer1_mode
	task automatic timer2_mode;
		run = 1'b0;
		ovf = 1'b1;
		tsel = 1'b1;
		settle(400, 16'h0020, 16'h0010);
		overflow_gap(16'h0002);
		rsel = 1'b1;
		t2 = 16'hFFFE;
		settle(600, 16'h0040, 16'h0040);
		overflow_gap(16'h0004);
	endtask : timer2_mode
	// Selects cleared: both directions on the soft-reload timer
	task automatic soft_reload_mode;
		int k;
		tsel = 1'b0;
		rsel = 1'b0;
		ovf = 1'b0;
		dbl = 1'b0;
		mode = 2'h3;
		soft_run = 1'b1;
		settle(800, 16'h0080, 16'h0080);
		k = 0;
		repeat (16)
		begin
			@(negedge clock);
			k += int'(t2o !== 1'b0);
		end
		compare("idle overflows", 16'h0000, 16'(k));
	endtask : soft_reload_mode
	// Reset in mid-run, then the rate must come back
	task automatic reset_midway;
		reset = 1'b1;
		@(negedge clock);
		compare("ticks in reset", 16'h0000, {13'h0000, txt, rxt, t2o});
		reset = 1'b0;
		settle(800, 16'h0080, 16'h0080);
	endtask : reset_midway
	initial
	begin
		repeat (16) @(negedge clock);
		reset = 1'b0;
		shift_mode();
		fixed_mode();
		timer1_mode();
		timer2_mode();
		soft_reload_mode();
		reset_midway();
		summarize();
	end
endmodule : test_uart_baud_rate_generator
`default_nettype wire
